// [sim/event_source.sv]
// Far-side model: the on-chip trigger, restart, list-load and abort sources.
// Assumes the bench calls its tasks from one process in step with sys_clk.
`timescale 1ns/1ps
`default_nettype none
module event_source (
  input  wire logic sys_clk,
  output var logic  trigger_in,
  output var logic  restart_in,
  output var logic  list_swap_ready,
  output var logic  abort_in
);
  // ==========================================================================
  // Event drive
  initial begin
    trigger_in = 1'b0;
    restart_in = 1'b0;
    list_swap_ready = 1'b0;
    abort_in = 1'b0;
  end

  // Kind 0 is a trigger, any other a restart; one-cycle pulses only
  task automatic pulse(input int kind);
    @(posedge sys_clk);
    if (kind == 0) begin
      trigger_in <= 1'b1;
    end else begin
      restart_in <= 1'b1;
    end
    @(posedge sys_clk);
    trigger_in <= 1'b0;
    restart_in <= 1'b0;
  endtask

  // Abort is a level; only its rising edge counts, so it is raised while busy
  task automatic levels(input logic ready, input logic abort);
    @(posedge sys_clk);
    list_swap_ready <= ready;
    abort_in <= abort;
  endtask
endmodule
`default_nettype wire

// [sim/test_adc_sequence_flow_control.sv]
// Self-checking bench for the conversion flow control block.
// Assumes the partner model drives the on-chip event inputs.
`timescale 1ns/1ps
`default_nettype none
module test_adc_sequence_flow_control
  import conv_flow_pkg::*;
;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] exp;
  } row_s;
  logic       sys_clk;
  logic       rst_n;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  wire  [7:0] reg_rdata;
  wire        trigger_in;
  wire        restart_in;
  wire        list_swap_ready;
  wire        abort_in;
  wire        conv_tick;
  wire        converting;
  wire        active_list;
  int         mismatches;
  int         n_checks;
  logic [7:0] rdv;
  logic       a0;
  int         cnt;
  row_s       rows [12];

  conv_flow_ctrl i_conv_flow_ctrl (
    .sys_clk         (sys_clk),
    .rst_n           (rst_n),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .trigger_in      (trigger_in),
    .restart_in      (restart_in),
    .list_swap_ready (list_swap_ready),
    .abort_in        (abort_in),
    .conv_tick       (conv_tick),
    .converting      (converting),
    .active_list     (active_list)
  );
  event_source i_event_source (
    .sys_clk         (sys_clk),
    .trigger_in      (trigger_in),
    .restart_in      (restart_in),
    .list_swap_ready (list_swap_ready),
    .abort_in        (abort_in)
  );

  // ==========================================================================
  // Bus and check tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    // Data stand only in the cycle after the strobe
    #1;
    d = reg_rdata;
  endtask
  task automatic stat_bit(input int b, input logic e);
    rd(FLOW_STAT_OFF, rdv);
    check({7'h00, rdv[b]}, {7'h00, e});
  endtask
  // Bounded wait; a hang shows up as a mismatch, not a stall
  task automatic wait_conv(input logic lvl);
    int k;
    k = 0;
    while (converting !== lvl && k < 100) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    check({7'h00, converting}, {7'h00, lvl});
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock, watchdog, sequence
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    mismatches = 0;
    n_checks = 0;
    rows = '{
      '{1'b0, TIMING_OFF, 8'h00, {1'b0, DIV_RESET}},
      '{1'b0, FLOW_CFG_OFF, 8'h00, CFG_RESET},
      '{1'b0, 8'h20, 8'h00, 8'h00},
      '{1'b1, TIMING_OFF, 8'h02, 8'h00},
      '{1'b0, TIMING_OFF, 8'h00, 8'h02},
      '{1'b1, FLOW_CFG_OFF, 8'h01, 8'h00},
      '{1'b1, TIMING_OFF, 8'h7F, 8'h00},
      '{1'b0, TIMING_OFF, 8'h00, 8'h02},
      '{1'b1, FLOW_CFG_OFF, 8'h03, 8'h00},
      '{1'b1, TIMING_OFF, 8'h01, 8'h00},
      '{1'b0, TIMING_OFF, 8'h00, 8'h01},
      '{1'b1, FLOW_CFG_OFF, 8'h01, 8'h00}};
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].addr, rows[i].data);
      end else begin
        rd(rows[i].addr, rdv);
        check(rdv, rows[i].exp);
      end
    end
    // Divider 1 gives a tick every 4 bus clocks
    repeat (20) begin
      @(posedge sys_clk);
      #1;
      if (conv_tick === 1'b1) break;
    end
    cnt = 0;
    do begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end while (conv_tick !== 1'b1 && cnt < 20);
    check(cnt[7:0], 8'h04);
    // Hardware abort edge mid-conversion
    i_event_source.pulse(0);
    wait_conv(1'b1);
    i_event_source.levels(1'b0, 1'b1);
    wait_conv(1'b0);
    stat_bit(STAT_ABORT_REQUEST_BIT_BIT, 1'b0);
    stat_bit(STAT_IDLE_BIT, 1'b1);
    i_event_source.levels(1'b0, 1'b0);
    i_event_source.pulse(1);
    // Unexpected restart while busy
    i_event_source.pulse(0);
    wait_conv(1'b1);
    i_event_source.pulse(1);
    wait_conv(1'b0);
    stat_bit(STAT_REIF_BIT, 1'b1);
    wr(FLOW_CTRL_OFF, 8'h08);
    stat_bit(STAT_REIF_BIT, 1'b0);
    // List swap only once the other list is ready
    wr(FLOW_CFG_OFF, 8'h09);
    a0 = active_list;
    i_event_source.pulse(1);
    repeat (4) @(posedge sys_clk);
    check({7'h00, active_list}, {7'h00, a0});
    i_event_source.levels(1'b1, 1'b0);
    i_event_source.pulse(1);
    repeat (4) @(posedge sys_clk);
    check({7'h00, active_list}, {7'h00, ~a0});
    i_event_source.levels(1'b0, 1'b0);
    // Restart mode: software abort, restart, then a stray trigger
    wr(FLOW_CFG_OFF, 8'h05);
    wr(FLOW_CTRL_OFF, 8'h08);
    i_event_source.pulse(0);
    wait_conv(1'b1);
    wr(FLOW_CTRL_OFF, 8'h01);
    wait_conv(1'b0);
    i_event_source.pulse(1);
    stat_bit(STAT_REIF_BIT, 1'b0);
    i_event_source.pulse(0);
    wait_conv(1'b1);
    wr(FLOW_CTRL_OFF, 8'h01);
    wait_conv(1'b0);
    i_event_source.pulse(0);
    repeat (4) @(posedge sys_clk);
    stat_bit(STAT_TEIF_BIT, 1'b1);
    rd(FLOW_CTRL_OFF, rdv);
    check({7'h00, rdv[CTRL_CONVERSION_START_FLAG_BIT]}, 8'h01);
    // Mid-run reset, then one full list of four in trigger mode
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check({5'h00, conv_tick, converting, active_list}, 8'h00);
    check(reg_rdata, 8'h00);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(TIMING_OFF, rdv);
    check(rdv, {1'b0, DIV_RESET});
    rd(FLOW_STAT_OFF, rdv);
    check(rdv, 8'h04);
    wr(FLOW_CFG_OFF, 8'h01);
    repeat (4) begin
      i_event_source.pulse(0);
      wait_conv(1'b1);
      wait_conv(1'b0);
    end
    stat_bit(STAT_DONE_BIT, 1'b1);
    i_event_source.pulse(1);
    stat_bit(STAT_REIF_BIT, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire

// [src/conv_flow_ctrl.sv]
// Conversion flow control: clock prescaler, restart, abort and errors.
// Assumes synchronous strobes from on-chip logic and a simple reg port.
// Operation
// [R1] Conversion clock is bus clock over two times divider plus one.
// [R2] Timing register writes take effect only when disabled or in special mode.
// [R3] Restart before list swap ready restarts the active list, no swap.
// [R4] Restart at or after list swap ready swaps lists in double buffer mode.
// [R5] Abort stops at the next conversion boundary and drops the list.
// [R6] Abort comes from a rising abort input edge or a software write of one.
// [R7] Abort bit clears once the conversion ends or the list is dropped.
// [R8] Software sets abort only while busy or idle with list not done; the code sets it on any control write of one, in any state.
// [R9] In restart mode a restart must follow an abort before any trigger.
// [R10] A trigger after abort before restart sets start and error flags.
// [R11] After a restart, triggers are accepted from the active list top.
// [R12] A restart after an executed abort only performs the restart.
// [R13] A restart before end of list or abort automatically sets abort.
// [R14] An automatic abort from restart also sets the restart error flag.
// [R15] The conversion clock is a counter-based enable on the bus clock.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module conv_flow_ctrl
  import conv_flow_pkg::*;
#(
  parameter int LIST_LEN = 4
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       trigger_in,
  input  wire logic       restart_in,
  input  wire logic       list_swap_ready,
  input  wire logic       abort_in,
  output logic            conv_tick,
  output logic            converting,
  output logic            active_list
);

  initial begin
    if (LIST_LEN < 1 || LIST_LEN > 255) begin
      $error("LIST_LEN out of range");
    end
  end

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV, ST_HALT} flow_e;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ==========================================================================
  // Registers
  logic [6:0] clock_divider_reg;
  logic [7:0] cfg_reg;
  logic       abort_request_bit_reg;
  logic       restart_request_bit_reg;
  logic       conversion_start_flag_reg;
  logic       start_error_flag_reg;
  logic       restart_error_flag_reg;
  logic       aborted_reg;
  logic       list_done_reg;
  logic       abort_in_reg;
  logic [6:0] div_cnt_reg;
  logic [2:0] tick_cnt_reg;
  logic [7:0] cmd_idx_reg;
  flow_e      state_reg;

  logic en;
  logic smod;
  logic rmode;
  logic dbuf;
  logic wr_ctrl;
  logic sw_abort_request_bit;
  logic sw_restart_request_bit;
  logic sw_conversion_start_flag;
  logic sw_srst;
  logic abort_edge;
  logic restart_ev;
  logic conversion_start_flag_ev;
  logic boundary;
  logic idle;
  logic auto_abort;

  assign en      = cfg_reg[CFG_EN_BIT];
  assign smod    = cfg_reg[CFG_SMOD_BIT];
  assign rmode   = cfg_reg[CFG_RMODE_BIT];
  assign dbuf    = cfg_reg[CFG_DBUF_BIT];
  assign wr_ctrl = reg_wr && hit(reg_addr, FLOW_CTRL_OFF);
  assign sw_abort_request_bit = wr_ctrl && reg_wdata[CTRL_ABORT_REQUEST_BIT_BIT];
  assign sw_restart_request_bit = wr_ctrl && reg_wdata[CTRL_RESTART_REQUEST_BIT_BIT];
  assign sw_conversion_start_flag = wr_ctrl && reg_wdata[CTRL_CONVERSION_START_FLAG_BIT];
  assign sw_srst = wr_ctrl && reg_wdata[CTRL_SRST_BIT];
  assign abort_edge = abort_in && !abort_in_reg; // R6
  assign restart_ev = restart_in || sw_restart_request_bit;
  assign conversion_start_flag_ev    = trigger_in || sw_conversion_start_flag;
  assign idle       = (state_reg == ST_IDLE) || (state_reg == ST_WAIT);
  assign boundary   = conv_tick && (tick_cnt_reg == 3'(CONV_TICKS - 1));
  // Restart while list still running and no abort pending forces an abort
  assign auto_abort = restart_ev && !list_done_reg && !aborted_reg
                      && !abort_request_bit_reg && (state_reg != ST_IDLE); // R13

  // ==========================================================================
  // Timing and configuration registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_divider_reg <= DIV_RESET;
    end else if (reg_wr && hit(reg_addr, TIMING_OFF) && (!en || smod)) begin // R2
      clock_divider_reg <= reg_wdata[DIV_MSB:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= CFG_RESET;
    end else if (reg_wr && hit(reg_addr, FLOW_CFG_OFF)) begin
      cfg_reg <= reg_wdata;
    end
  end

  // ==========================================================================
  // Conversion clock enable: one pulse per (div+1) bus clocks gives a
  // half period, so a full converter clock spans 2x(div+1) bus clocks.
  logic half_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= 7'h00;
      half_reg    <= 1'b0;
      conv_tick   <= 1'b0;
    end else if (div_cnt_reg >= clock_divider_reg) begin // R15
      div_cnt_reg <= 7'h00;
      half_reg    <= !half_reg;
      conv_tick   <= half_reg && en; // R1
    end else begin
      div_cnt_reg <= div_cnt_reg + 7'h01;
      conv_tick   <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      abort_in_reg <= 1'b0;
    end else begin
      abort_in_reg <= abort_in;
    end
  end

  // ==========================================================================
  // Abort and restart request bits, restart error flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      abort_request_bit_reg <= 1'b0;
    end else if (abort_edge || sw_abort_request_bit || auto_abort) begin // R6
      abort_request_bit_reg <= 1'b1;
    end else if (abort_request_bit_reg && (idle || boundary)) begin // R7
      abort_request_bit_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      restart_request_bit_reg <= 1'b0;
    end else if (restart_ev) begin // R12
      restart_request_bit_reg <= 1'b1;
    end else if (!abort_request_bit_reg) begin
      restart_request_bit_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      restart_error_flag_reg <= 1'b0;
    end else if (auto_abort) begin // R14
      restart_error_flag_reg <= 1'b1;
    end else if (sw_srst) begin
      restart_error_flag_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Sequence state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg                 <= ST_IDLE;
      aborted_reg               <= 1'b0;
      list_done_reg             <= 1'b0;
      active_list               <= 1'b0;
      cmd_idx_reg               <= 8'h00;
      tick_cnt_reg              <= 3'h0;
      conversion_start_flag_reg <= 1'b0;
      start_error_flag_reg      <= 1'b0;
      converting                <= 1'b0;
    end else if (sw_srst) begin
      state_reg                 <= ST_IDLE;
      aborted_reg               <= 1'b0;
      list_done_reg             <= 1'b0;
      cmd_idx_reg               <= 8'h00;
      tick_cnt_reg              <= 3'h0;
      conversion_start_flag_reg <= 1'b0;
      start_error_flag_reg      <= 1'b0;
      converting                <= 1'b0;
    end else begin
      if (restart_ev && state_reg != ST_HALT) begin
        cmd_idx_reg   <= 8'h00; // R3
        list_done_reg <= 1'b0;
        aborted_reg   <= 1'b0; // R11
        if (list_swap_ready && dbuf) begin
          active_list <= !active_list; // R4
        end
        if (!auto_abort) begin
          state_reg <= ST_WAIT;
        end
      end else if (abort_request_bit_reg && (idle || boundary)) begin
        state_reg    <= ST_WAIT; // R5
        aborted_reg  <= 1'b1;
        converting   <= 1'b0;
        tick_cnt_reg <= 3'h0;
        cmd_idx_reg  <= 8'h00;
      end else if (conversion_start_flag_ev && aborted_reg && rmode) begin
        conversion_start_flag_reg <= 1'b1; // R10
        start_error_flag_reg      <= 1'b1;
        state_reg                 <= ST_HALT;
      end else if (conversion_start_flag_ev && en && idle && !list_done_reg) begin
        conversion_start_flag_reg <= 1'b1;
        state_reg                 <= ST_CONV;
        converting                <= 1'b1;
      end else if (state_reg == ST_CONV && conv_tick) begin
        if (boundary) begin
          tick_cnt_reg <= 3'h0;
          converting   <= 1'b0;
          conversion_start_flag_reg <= 1'b0;
          if (cmd_idx_reg == 8'(LIST_LEN - 1)) begin
            list_done_reg <= 1'b1;
            state_reg     <= ST_IDLE;
          end else begin
            cmd_idx_reg <= cmd_idx_reg + 8'h01;
            state_reg   <= ST_WAIT;
          end
        end else begin
          tick_cnt_reg <= tick_cnt_reg + 3'h1;
        end
      end
    end
  end

  // ==========================================================================
  // Read port
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        TIMING_OFF:    reg_rdata <= {1'b0, clock_divider_reg};
        FLOW_CTRL_OFF: reg_rdata <= {4'h0, 1'b0, conversion_start_flag_reg,
                                     restart_request_bit_reg,
                                     abort_request_bit_reg};
        FLOW_STAT_OFF: reg_rdata <= {restart_request_bit_reg,
                                     abort_request_bit_reg,
                                     state_reg == ST_HALT, active_list,
                                     list_done_reg || aborted_reg, idle,
                                     restart_error_flag_reg,
                                     start_error_flag_reg};
        FLOW_CFG_OFF:  reg_rdata <= cfg_reg;
        default:       reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================================
  // Checks
  chk_timing_guard: assert property ( // R2
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && hit(reg_addr, TIMING_OFF) && en && !smod)
    |=> $stable(clock_divider_reg))
    else $error("timing register changed while locked");
  chk_abort_edge: assert property ( // R6
    @(posedge sys_clk) disable iff (!rst_n)
    (abort_edge && !sw_srst) |=> abort_request_bit_reg)
    else $error("abort edge not taken");
  chk_auto_err: assert property ( // R14
    @(posedge sys_clk) disable iff (!rst_n)
    auto_abort |=> (restart_error_flag_reg && abort_request_bit_reg))
    else $error("auto abort without restart error");
  chk_conversion_start_flag_halt: assert property ( // R10
    @(posedge sys_clk) disable iff (!rst_n)
    (conversion_start_flag_ev && aborted_reg && rmode && !restart_ev && !sw_srst
     && !abort_request_bit_reg) |=> start_error_flag_reg)
    else $error("trigger after abort not flagged");
  chk_no_swap: assert property ( // R3
    @(posedge sys_clk) disable iff (!rst_n)
    (restart_ev && !list_swap_ready && !sw_srst && state_reg != ST_HALT)
    |=> $stable(active_list) && cmd_idx_reg == 8'h00)
    else $error("list swapped early");
  chk_swap: assert property ( // R4
    @(posedge sys_clk) disable iff (!rst_n)
    (restart_ev && list_swap_ready && dbuf && !sw_srst
     && state_reg != ST_HALT) |=> active_list != $past(active_list))
    else $error("list not swapped");
  chk_abort_stop: assert property ( // R5
    @(posedge sys_clk) disable iff (!rst_n)
    (abort_request_bit_reg && boundary && !restart_ev && !sw_srst)
    |=> !converting && aborted_reg)
    else $error("abort did not stop conversion");
  chk_tick_space: assert property ( // R1
    @(posedge sys_clk) disable iff (!rst_n)
    conv_tick |=> !conv_tick)
    else $error("converter clock enable too fast");
  chk_abort_clear: assert property ( // R7
    @(posedge sys_clk) disable iff (!rst_n)
    (abort_request_bit_reg && boundary && !abort_edge && !sw_abort_request_bit
     && !auto_abort) |=> !abort_request_bit_reg)
    else $error("abort request not cleared");
  chk_idle_abort: assert property ( // R5
    @(posedge sys_clk) disable iff (!rst_n)
    (abort_request_bit_reg && idle && !restart_ev && !sw_srst)
    |=> (state_reg == ST_WAIT && aborted_reg))
    else $error("abort while idle not executed");
  chk_sw_abort: assert property ( // R6
    @(posedge sys_clk) disable iff (!rst_n)
    sw_abort_request_bit |=> abort_request_bit_reg)
    else $error("software abort not taken");
  chk_done_no_err: assert property ( // R13
    @(posedge sys_clk) disable iff (!rst_n)
    (restart_ev && list_done_reg && !restart_error_flag_reg)
    |=> !restart_error_flag_reg)
    else $error("restart after end of list flagged");
  chk_halt_hold: assert property ( // R10
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ST_HALT && !sw_srst) |=> state_reg == ST_HALT)
    else $error("halt left without soft reset");
  chk_rd_timing: assert property ( // R2
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && hit(reg_addr, TIMING_OFF))
    |=> reg_rdata == {1'b0, $past(clock_divider_reg)})
    else $error("timing register read back wrong");
  chk_tick_en: assert property ( // R15
    @(posedge sys_clk) disable iff (!rst_n)
    !en |=> !conv_tick)
    else $error("converter clock runs while disabled");
  chk_conv_start: assert property ( // R11
    @(posedge sys_clk) disable iff (!rst_n)
    (conversion_start_flag_ev && en && idle && !list_done_reg && !aborted_reg
     && !restart_ev && !abort_request_bit_reg && !sw_srst)
    |=> converting)
    else $error("trigger did not start a conversion");
  chk_restart_bit: assert property ( // R12
    @(posedge sys_clk) disable iff (!rst_n)
    restart_ev |=> restart_request_bit_reg)
    else $error("restart request bit not set");

endmodule
`default_nettype wire

// [src/conv_flow_pkg.sv]
// Constants for the converter flow control block.
// Assumes a byte-wide register port with one-cycle read latency.
package conv_flow_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] TIMING_OFF    = 8'h03;
  localparam logic [7:0] FLOW_CTRL_OFF = 8'h10;
  localparam logic [7:0] FLOW_STAT_OFF = 8'h11;
  localparam logic [7:0] FLOW_CFG_OFF  = 8'h12;

  // ==========================================================================
  // Field positions
  localparam int DIV_MSB       = 6;
  localparam int CTRL_ABORT_REQUEST_BIT_BIT = 0;
  localparam int CTRL_RESTART_REQUEST_BIT_BIT = 1;
  localparam int CTRL_CONVERSION_START_FLAG_BIT = 2;
  localparam int CTRL_SRST_BIT = 3;
  localparam int STAT_TEIF_BIT = 0;
  localparam int STAT_REIF_BIT = 1;
  localparam int STAT_IDLE_BIT = 2;
  localparam int STAT_DONE_BIT = 3;
  localparam int STAT_LIST_BIT = 4;
  localparam int STAT_HALT_BIT = 5;
  localparam int STAT_ABORT_REQUEST_BIT_BIT = 6;
  localparam int STAT_RESTART_REQUEST_BIT_BIT = 7;
  localparam int CFG_EN_BIT    = 0;
  localparam int CFG_SMOD_BIT  = 1;
  localparam int CFG_RMODE_BIT = 2;
  localparam int CFG_DBUF_BIT  = 3;

  // ==========================================================================
  // Reset values
  localparam logic [6:0] DIV_RESET = 7'h05;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Conversion cycles per command, in converter clock ticks
  localparam int CONV_TICKS = 4;

endpackage
